// >>> core/pmts_pkg.sv
// Purpose: constants and types for the medium type select register bank
// Assumes: one management device number, 16-bit register words
// Notes: all offsets, fixed values and field positions live here
// Function
// - bank sits in management device 0x01, offsets 0x0005 to 0x0007, 16 bits each.
// - low devices-present register is read-only and always returns 0x008B.
// - high devices-present register is read-only and always returns 0xC000.
// - control register holds read-write type field bits 6:0, reset 0x3D, rest reserved.
// - type field drives operation only with autonegotiation off and forced configuration on.
// - with autonegotiation on, the type comes from the negotiation outcome only.
package pmts_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [4:0] MMD_PMA_PMD = 5'h01;
    localparam logic [15:0] OFS_DEV_LOW = 16'h0005;
    localparam logic [15:0] OFS_DEV_HIGH = 16'h0006;
    localparam logic [15:0] OFS_TYPE_CTRL = 16'h0007;
    // ----------------------------------------------------------------
    // fixed values and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] DEV_LOW_VALUE = 16'h008B;
    localparam logic [15:0] DEV_HIGH_VALUE = 16'hC000;
    localparam logic [15:0] TYPE_CTRL_RESET = 16'h003D;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    // ----------------------------------------------------------------
    // type field layout and codes
    // ----------------------------------------------------------------
    localparam int TYPE_FIELD_LSB = 0;
    localparam int TYPE_FIELD_W = 7;
    localparam int TYPE_FIELD_MSB = TYPE_FIELD_LSB + TYPE_FIELD_W - 1;
    localparam logic [8:0] TYPE_CTRL_RSVD = 9'h000;
    localparam logic [6:0] TYPE_RESET = TYPE_CTRL_RESET[6:0];
    localparam logic [6:0] TYPE_BASE_T1 = 7'h3D;
    localparam logic [6:0] TYPE_CX4 = 7'h00;
    // ----------------------------------------------------------------
    // source of the operating type
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_HOLD,
        SRC_AUTONEG,
        SRC_FORCED
    } pmts_src_t;
endpackage : pmts_pkg

// >>> core/pmts_top.sv
// Purpose: devices-present and medium type control registers of the PMA/PMD device
// Assumes: management requests come from logic on clk_sys_i, one cycle each
// Notes: answer comes one cycle after the request; other addresses get no hit
`timescale 1ns/100ps
module pmts_top (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [4:0] mgmt_dev_addr_i,
    input wire logic [15:0] mgmt_reg_addr_i,
    input wire logic mgmt_wr_i,
    input wire logic mgmt_rd_i,
    input wire logic [15:0] mgmt_wdata_i,
    output logic [15:0] mgmt_rdata_o,
    output logic mgmt_ack_o,
    output logic mgmt_hit_o,
    input wire logic an_enable_i,
    input wire logic forced_cfg_i,
    input wire logic [6:0] an_type_i,
    input wire logic an_valid_i,
    output logic [6:0] active_type_o,
    output logic type_forced_o,
    output logic type_invalid_o
);
    pmts_type_if ti ();

    logic [6:0] type_field;
    logic [6:0] next_type_field;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic ack;
    logic next_ack;
    logic hit;
    logic next_hit;
    logic dev_match;
    logic sel_low;
    logic sel_high;
    logic sel_ctrl;
    logic any_req;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    always_comb begin
        dev_match = (mgmt_dev_addr_i == pmts_pkg::MMD_PMA_PMD);
        sel_low = dev_match && (mgmt_reg_addr_i == pmts_pkg::OFS_DEV_LOW);
        sel_high = dev_match && (mgmt_reg_addr_i == pmts_pkg::OFS_DEV_HIGH);
        sel_ctrl = dev_match && (mgmt_reg_addr_i == pmts_pkg::OFS_TYPE_CTRL);
        any_req = mgmt_wr_i || mgmt_rd_i;
    end

    // ----------------------------------------------------------------
    // register state and answer
    // ----------------------------------------------------------------
    always_comb begin
        next_type_field = type_field;
        next_rdata = pmts_pkg::ZERO_WORD;
        next_ack = any_req;
        next_hit = any_req && (sel_low || sel_high || sel_ctrl);
        // a write wins over a read in the same cycle; the answer is then empty
        if (mgmt_wr_i) begin
            if (sel_ctrl) begin
                // reserved bits of the write are dropped
                next_type_field = mgmt_wdata_i[pmts_pkg::TYPE_FIELD_MSB:pmts_pkg::TYPE_FIELD_LSB];
            end
            // writes to the fixed registers change nothing
        end else if (mgmt_rd_i) begin
            if (sel_low) begin
                next_rdata = pmts_pkg::DEV_LOW_VALUE;
            end else if (sel_high) begin
                next_rdata = pmts_pkg::DEV_HIGH_VALUE;
            end else if (sel_ctrl) begin
                next_rdata = {pmts_pkg::TYPE_CTRL_RSVD, type_field};
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            type_field <= pmts_pkg::TYPE_RESET;
            rdata <= pmts_pkg::ZERO_WORD;
            ack <= 1'b0;
            hit <= 1'b0;
        end else begin
            type_field <= next_type_field;
            rdata <= next_rdata;
            ack <= next_ack;
            hit <= next_hit;
        end
    end

    // ----------------------------------------------------------------
    // type selection
    // ----------------------------------------------------------------
    assign ti.type_field = type_field;
    assign ti.an_enable = an_enable_i;
    assign ti.forced_cfg = forced_cfg_i;
    assign ti.an_type = an_type_i;
    assign ti.an_valid = an_valid_i;

    pmts_type_sel u_sel (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ti(ti.sel)
    );

    assign mgmt_rdata_o = rdata;
    assign mgmt_ack_o = ack;
    assign mgmt_hit_o = hit;
    assign active_type_o = ti.active_type;
    assign type_forced_o = (ti.src == pmts_pkg::SRC_FORCED);
    assign type_invalid_o = ti.type_invalid;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_map_location: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (any_req && !dev_match) |=> (mgmt_ack_o && !mgmt_hit_o && mgmt_rdata_o == pmts_pkg::ZERO_WORD))
        else $error("request outside the device got a hit");

    chk_dev_low_read: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (mgmt_rd_i && !mgmt_wr_i && sel_low) |=> (mgmt_hit_o && mgmt_rdata_o == pmts_pkg::DEV_LOW_VALUE))
        else $error("low devices-present read returned wrong value");

    chk_dev_high_read: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (mgmt_rd_i && !mgmt_wr_i && sel_high) |=> (mgmt_hit_o && mgmt_rdata_o == pmts_pkg::DEV_HIGH_VALUE))
        else $error("high devices-present read returned wrong value");

    chk_field_write: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (mgmt_wr_i && sel_ctrl) ##1 (mgmt_rd_i && !mgmt_wr_i && sel_ctrl)
        |=> (mgmt_rdata_o == {pmts_pkg::TYPE_CTRL_RSVD, $past(mgmt_wdata_i[6:0], 2)}))
        else $error("control register read-back differs from written field");

    chk_forced_apply: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (!an_enable_i && forced_cfg_i) |=> (active_type_o == $past(type_field) && type_forced_o))
        else $error("forced mode did not apply the type field");

    chk_hold_unforced: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (!an_enable_i && !forced_cfg_i) |=> $stable(active_type_o))
        else $error("type changed outside forced and negotiated modes");

    chk_an_apply: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (an_enable_i && an_valid_i) |=> (active_type_o == $past(an_type_i) && !type_forced_o))
        else $error("negotiated type not applied");

    chk_type_flag: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (mgmt_wr_i && sel_ctrl) |-> ##2 (type_invalid_o == ($past(mgmt_wdata_i[6:0], 2) != pmts_pkg::TYPE_BASE_T1)))
        else $error("invalid type flag wrong after a field write");

    chk_ro_ignore: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (mgmt_wr_i && (sel_low || sel_high || !dev_match)) |=> $stable(type_field))
        else $error("write to a fixed register changed the type field");

    chk_ack_every: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        any_req |=> mgmt_ack_o)
        else $error("request got no acknowledge");

    chk_idle_quiet: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        !any_req |=> (!mgmt_ack_o && !mgmt_hit_o && mgmt_rdata_o == pmts_pkg::ZERO_WORD))
        else $error("answer shown without a request");

    chk_ctrl_hit: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (any_req && sel_ctrl) |=> mgmt_hit_o)
        else $error("control register request got no hit");

    chk_hit_with_ack: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        mgmt_hit_o |-> mgmt_ack_o)
        else $error("hit shown without acknowledge");

    chk_ctrl_read: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (mgmt_rd_i && !mgmt_wr_i && sel_ctrl)
        |=> (mgmt_hit_o && mgmt_rdata_o == {pmts_pkg::TYPE_CTRL_RSVD, $past(type_field)}))
        else $error("control register read returned wrong word");

    chk_field_keep: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        !(mgmt_wr_i && sel_ctrl) |=> $stable(type_field))
        else $error("type field changed without a control write");

    // no disable here: this one must look at the cycles while reset is held
    chk_reset_values: assert property (
        @(posedge clk_sys_i)
        !rst_b_i |=> (type_field == pmts_pkg::TYPE_RESET && active_type_o == pmts_pkg::TYPE_RESET
            && !type_forced_o && !type_invalid_o && !mgmt_ack_o && mgmt_rdata_o == pmts_pkg::ZERO_WORD))
        else $error("state after reset differs from reset values");

    chk_src_unforced: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (an_enable_i || !forced_cfg_i) |=> !type_forced_o)
        else $error("forced source shown outside forced mode");

    chk_an_hold: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (an_enable_i && !an_valid_i) |=> $stable(active_type_o))
        else $error("type changed while negotiation had no result");

    chk_flag_follows: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        1'b1 |=> (type_invalid_o == ($past(type_field) != pmts_pkg::TYPE_BASE_T1)))
        else $error("invalid type flag does not follow the field");

    chk_write_empty: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        mgmt_wr_i |=> (mgmt_ack_o && mgmt_rdata_o == pmts_pkg::ZERO_WORD))
        else $error("write returned read data");

    chk_rd_no_change: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (mgmt_rd_i && !mgmt_wr_i) |=> $stable(type_field))
        else $error("read changed the type field");
endmodule : pmts_top

// >>> core/pmts_type_if.sv
// Purpose: carries the type field and selection results between bank and selector
// Assumes: single clock domain
// Notes: bank drives the field and link-mode inputs, selector returns results
`timescale 1ns/100ps
interface pmts_type_if;
    logic [6:0] type_field;
    logic an_enable;
    logic forced_cfg;
    logic [6:0] an_type;
    logic an_valid;
    logic [6:0] active_type;
    pmts_pkg::pmts_src_t src;
    logic type_invalid;

    modport bank (
        output type_field,
        output an_enable,
        output forced_cfg,
        output an_type,
        output an_valid,
        input active_type,
        input src,
        input type_invalid
    );
    modport sel (
        input type_field,
        input an_enable,
        input forced_cfg,
        input an_type,
        input an_valid,
        output active_type,
        output src,
        output type_invalid
    );
endinterface : pmts_type_if

// >>> core/pmts_type_sel.sv
// Purpose: chooses the operating medium type from the field or the autonegotiation outcome
// Assumes: link-mode inputs are from logic on the same clock
// Notes: outside both modes the last operating type is held
`timescale 1ns/100ps
module pmts_type_sel (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    pmts_type_if.sel ti
);
    logic [6:0] active_type;
    logic [6:0] next_active_type;
    pmts_pkg::pmts_src_t src;
    pmts_pkg::pmts_src_t next_src;
    logic type_invalid;
    logic next_type_invalid;

    // ----------------------------------------------------------------
    // selection
    // ----------------------------------------------------------------
    always_comb begin
        next_active_type = active_type;
        next_src = pmts_pkg::SRC_HOLD;
        if (ti.an_enable) begin
            next_src = pmts_pkg::SRC_AUTONEG;
            // field ignored while negotiating
            if (ti.an_valid) begin
                next_active_type = ti.an_type;
            end
        end else if (ti.forced_cfg) begin
            next_src = pmts_pkg::SRC_FORCED;
            next_active_type = ti.type_field;
        end
        // any field code is applied; a field other than the BASE-T1 code is flagged
        next_type_invalid = (ti.type_field != pmts_pkg::TYPE_BASE_T1);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            active_type <= pmts_pkg::TYPE_RESET;
            src <= pmts_pkg::SRC_HOLD;
            type_invalid <= 1'b0;
        end else begin
            active_type <= next_active_type;
            src <= next_src;
            type_invalid <= next_type_invalid;
        end
    end

    assign ti.active_type = active_type;
    assign ti.src = src;
    assign ti.type_invalid = type_invalid;
endmodule : pmts_type_sel

// >>> test/test_pmts_top.sv
// Purpose: self-checking bench for the medium type select register bank
// Assumes: one request per access, ack seen just after the taking edge
// Notes: expectations come from a small field model kept in the bench
`timescale 1ns/100ps
module test_pmts_top;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [4:0] dev = 5'h00;
    logic [15:0] adr = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] wd = 16'h0000;
    logic [15:0] rdata;
    logic ack;
    logic hit;
    logic an_en = 1'b0;
    logic forced = 1'b0;
    logic [6:0] an_ty = 7'h00;
    logic an_val = 1'b0;
    logic [6:0] act;
    logic tforced;
    logic tinv;
    logic [6:0] field = 7'h3D;
    int miscompares = 0;
    int comparisons = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    pmts_top dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .mgmt_dev_addr_i(dev), .mgmt_reg_addr_i(adr),
        .mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_wdata_i(wd), .mgmt_rdata_o(rdata), .mgmt_ack_o(ack),
        .mgmt_hit_o(hit), .an_enable_i(an_en), .forced_cfg_i(forced), .an_type_i(an_ty),
        .an_valid_i(an_val), .active_type_o(act), .type_forced_o(tforced), .type_invalid_o(tinv));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check

    function automatic logic ours(input logic [4:0] d, input logic [15:0] a);
        return d == 5'h01 && a >= 16'h0005 && a <= 16'h0007;
    endfunction : ours

    function automatic logic [15:0] exp_read(input logic [15:0] a);
        case (a)
            16'h0005: return 16'h008B;
            16'h0006: return 16'hC000;
            default: return {9'h000, field};
        endcase
    endfunction : exp_read

    // one access; strobes drop after the answer edge, so calls never collide
    task automatic access(input logic w, input logic [4:0] d, input logic [15:0] a, input logic [15:0] v);
        logic [15:0] e;
        @(posedge clk_sys_i);
        #1;
        wr = w;
        rd = ~w;
        dev = d;
        adr = a;
        wd = v;
        e = (!w && ours(d, a)) ? exp_read(a) : 16'h0000;
        @(posedge clk_sys_i);
        #1;
        wr = 1'b0;
        rd = 1'b0;
        check({15'h0000, ack}, 16'h0001);
        check({15'h0000, hit}, {15'h0000, ours(d, a)});
        check(rdata, e);
        if (w && d == 5'h01 && a == 16'h0007) begin
            field = v[6:0];
        end
    endtask : access

    task automatic step;
        @(posedge clk_sys_i);
        #1;
        @(posedge clk_sys_i);
        #1;
    endtask : step

    task automatic complete_run;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    initial begin
        logic [15:0] a;
        logic [4:0] d;
        void'($urandom(32'h5ab6));
        repeat (3) @(posedge clk_sys_i);
        #1;
        rst_b_i = 1'b1;
        check({9'h000, act}, 16'h003D);
        check({14'h0000, tforced, tinv}, 16'h0000);
        for (int i = 5; i <= 7; i++) begin
            access(1'b0, 5'h01, i[15:0], 16'h0000);
        end
        // random mix of reads and writes, ours and foreign
        repeat (40) begin
            a = ($urandom_range(0, 4) < 3) ? 16'h0005 + 16'($urandom_range(0, 2)) : 16'($urandom());
            d = ($urandom_range(0, 3) == 0) ? 5'($urandom()) : 5'h01;
            access(1'($urandom()), d, a, 16'($urandom()));
            step();
            check({15'h0000, tinv}, {15'h0000, field != 7'h3D});
        end
        access(1'b1, 5'h01, 16'h0005, 16'hFFFF);
        access(1'b1, 5'h01, 16'h0006, 16'h0000);
        access(1'b1, 5'h01, 16'h0007, 16'hFF80);
        for (int i = 5; i <= 7; i++) begin
            access(1'b0, 5'h01, i[15:0], 16'h0000);
        end
        check({15'h0000, tinv}, 16'h0001);
        // forced mode applies the field, also a foreign code
        an_en = 1'b0;
        forced = 1'b1;
        step();
        check({8'h00, tforced, act}, {9'h001, field});
        access(1'b1, 5'h01, 16'h0007, 16'h003D);
        step();
        check({8'h00, tforced, act}, {9'h001, 7'h3D});
        check({15'h0000, tinv}, 16'h0000);
        // negotiation overrides the field even with forced mode on
        an_ty = 7'($urandom());
        an_val = 1'b1;
        an_en = 1'b1;
        access(1'b1, 5'h01, 16'h0007, 16'h0011);
        step();
        check({8'h00, tforced, act}, {9'h000, an_ty});
        check({15'h0000, tinv}, 16'h0001);
        // no negotiation result: last type held
        an_val = 1'b0;
        an_ty = ~an_ty;
        step();
        check({8'h00, tforced, act}, {9'h000, ~an_ty});
        // neither mode: field ignored, last type held
        an_en = 1'b0;
        forced = 1'b0;
        an_val = 1'b0;
        step();
        check({8'h00, tforced, act}, {9'h000, ~an_ty});
        // write and read together count as a write with an empty answer
        @(posedge clk_sys_i);
        #1;
        wr = 1'b1;
        rd = 1'b1;
        dev = 5'h01;
        adr = 16'h0007;
        wd = 16'h0055;
        @(posedge clk_sys_i);
        #1;
        wr = 1'b0;
        rd = 1'b0;
        check({14'h0000, ack, hit}, 16'h0003);
        check(rdata, 16'h0000);
        field = 7'h55;
        access(1'b0, 5'h01, 16'h0007, 16'h0000);
        complete_run();
    end
endmodule : test_pmts_top
